// file: bench/io_port_register_set_tb_top.sv
`timescale 1ns/1ps
module io_port_register_set_tb_top;
  import io_port_pkg::*;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] lvl [4];
  logic [7:0] drv [4];
  logic [7:0] oe_n [4];
  logic [7:0] pu [4];
  logic [7:0] ext [4] = '{8'h00, 8'hFF, 8'h00, 8'hF0};
  logic [7:0] rst_addr [9] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h35};
  int error_cnt = 0;
  int samples_checked = 0;
  io_port_register_set uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .port_b_pin_in(lvl[0]), .port_c_pin_in(lvl[1]),
    .port_d_pin_in(lvl[2]), .port_e_pin_in(lvl[3]), .port_b_pin_out(drv[0]),
    .port_c_pin_out(drv[1]), .port_d_pin_out(drv[2]), .port_e_pin_out(drv[3]),
    .port_b_pin_oe_n_out(oe_n[0]), .port_c_pin_oe_n_out(oe_n[1]),
    .port_d_pin_oe_n_out(oe_n[2]), .port_e_pin_oe_n_out(oe_n[3]),
    .port_b_pullup_out(pu[0]), .port_c_pullup_out(pu[1]),
    .port_d_pullup_out(pu[2]), .port_e_pullup_out(pu[3]));
  for (genvar i = 0; i < 4; i++) begin : g_pin
    pin_board board (.drive_in(drv[i]), .oe_n_in(oe_n[i]), .pullup_in(pu[i]),
      .ext_in(ext[i]), .level_out(lvl[i]));
  end
  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look just after that edge
  task automatic rd_chk(logic [7:0] a, logic [7:0] e, string n);
    @(posedge core_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // the tests need well under 200 cycles; allow ten times that
  initial begin
    #40000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    foreach (rst_addr[i]) rd_chk(rst_addr[i], 8'h00, "reset");
    for (int p = 0; p < 4; p++) begin
      wr_reg(8'h04 + 8'(3 * p), 8'hFF);
      wr_reg(8'h05 + 8'(3 * p), 8'hFF);
      rd_chk(8'h04 + 8'(3 * p), p == 1 ? PORT_C_MASK : 8'hFF, "dir");
      rd_chk(8'h05 + 8'(3 * p), p == 1 ? PORT_C_MASK : 8'hFF, "latch");
    end
    chk("pin_b", 8'hFF, drv[0]);
    chk("pin_e", 8'h0F, drv[3]);
    chk("pin_c", 8'h7F, drv[1]);
    chk("pin_d", 8'hFF, drv[2]);
    chk("oe_n_c", 8'h80, oe_n[1]);
    chk("oe_n_e", 8'hF0, oe_n[3]);
    rd_chk(OFF_E_IN, 8'hFF, "pin_e_in");
    rd_chk(OFF_C_IN, 8'h7F, "pin_c");
    wr_reg(OFF_B_IN, 8'h0F);
    rd_chk(OFF_B_OUT, 8'hF0, "toggle");
    wr_reg(OFF_B_DIR, 8'h00);
    repeat (4) @(posedge core_clk_in);
    chk("pullup_b", 8'hF0, pu[0]);
    rd_chk(OFF_B_IN, 8'hF0, "pin_b_in");
    wr_reg(OFF_MCU_CTRL, 8'h10);
    rd_chk(OFF_MCU_CTRL, 8'h10, "mcu");
    repeat (4) @(posedge core_clk_in);
    chk("pud_b", 8'h00, pu[0]);
    rd_chk(OFF_B_IN, 8'h00, "pud_in");
    wr_reg(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00, "unmapped");
    end_of_test();
  end
endmodule
bind io_port_register_set io_port_sva chk_i (.core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .port_b_pin_out(port_b_pin_out), .port_b_pin_oe_n_out(port_b_pin_oe_n_out),
  .port_c_pin_oe_n_out(port_c_pin_oe_n_out), .port_e_pin_oe_n_out(port_e_pin_oe_n_out),
  .port_b_pullup_out(port_b_pullup_out));

// file: bench/io_port_sva.sv
`timescale 1ns/1ps
module io_port_sva
  import io_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_pin_oe_n_out,
  input wire logic [7:0] port_c_pin_oe_n_out,
  input wire logic [7:0] port_e_pin_oe_n_out,
  input wire logic [7:0] port_b_pullup_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // pins follow a latch write two edges later, only where driven
  latch_to_pin_a: assert property (reg_wr_in && reg_addr_in == OFF_B_OUT |=> ##1
    ((port_b_pin_out ^ $past(reg_wdata_in, 2)) & ~port_b_pin_oe_n_out) == 8'h00)
    else $error("port b pins differ from written latch");
  c_bit7_rd_a: assert property (reg_rd_in && reg_addr_in inside {8'h06, 8'h07, 8'h08}
    |=> !reg_rdata_out[7]) else $error("port c bit 7 read as one");
  e_upper_a: assert property (port_e_pin_oe_n_out[7:4] == 4'hF)
    else $error("port e upper bit driven");
  undriven_zero_a: assert property ((port_b_pin_out & port_b_pin_oe_n_out) == 8'h00)
    else $error("undriven pin shows a drive value");
  pull_on_input_a: assert property ((port_b_pullup_out & ~port_b_pin_oe_n_out) == 8'h00)
    else $error("pull-up on a driven pin");
  c_pin7_a: assert property (port_c_pin_oe_n_out[7])
    else $error("port c bit 7 driven");
  dir_reset_a: assert property ($fell(sys_rst_in) |-> &port_b_pin_oe_n_out)
    else $error("pins driven after reset");
  pud_off_a: assert property (reg_wr_in && reg_addr_in == OFF_MCU_CTRL &&
    reg_wdata_in[PUD_BIT] |=> ##1 port_b_pullup_out == 8'h00)
    else $error("pull-up still on after global disable");
  wr_b_c: cover property (reg_wr_in && reg_addr_in == OFF_B_IN);
  pull_c: cover property (port_b_pullup_out != 8'h00);
  rd_c: cover property (reg_rd_in ##1 reg_rdata_out != 8'h00);
endmodule

// file: bench/pin_board.sv
`timescale 1ns/1ps
module pin_board (
  input wire logic [7:0] drive_in,
  input wire logic [7:0] oe_n_in,
  input wire logic [7:0] pullup_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] level_out
);
  // a driven pin wins; an undriven one sees pull-up or board level, never a held value
  always_comb begin
    level_out = (~oe_n_in & drive_in) | (oe_n_in & (pullup_in | ext_in));
  end
endmodule

// file: logic/io_port_pkg.sv
package io_port_pkg;
  // register offsets on the plain port
  localparam logic [7:0] OFF_B_IN = 8'h03;
  localparam logic [7:0] OFF_B_DIR = 8'h04;
  localparam logic [7:0] OFF_B_OUT = 8'h05;
  localparam logic [7:0] OFF_C_IN = 8'h06;
  localparam logic [7:0] OFF_C_DIR = 8'h07;
  localparam logic [7:0] OFF_C_OUT = 8'h08;
  localparam logic [7:0] OFF_D_IN = 8'h09;
  localparam logic [7:0] OFF_D_DIR = 8'h0A;
  localparam logic [7:0] OFF_D_OUT = 8'h0B;
  localparam logic [7:0] OFF_E_IN = 8'h0C;
  localparam logic [7:0] OFF_E_DIR = 8'h0D;
  localparam logic [7:0] OFF_E_OUT = 8'h0E;
  localparam logic [7:0] OFF_MCU_CTRL = 8'h35;
  // field layout and reset values
  localparam int PUD_BIT = 4;
  // bits 6, 5, 4, 1 and 0 are writable; bits 7, 3 and 2 read zero
  localparam logic [7:0] MCU_CTRL_WMASK = 8'h73;
  localparam logic [7:0] PORT_C_MASK = 8'h7F;
  localparam logic [7:0] PORT_E_PIN_MASK = 8'h0F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NUM_PORTS = 4;
  localparam int PORT_B = 0;
  localparam int PORT_C = 1;
  localparam int PORT_D = 2;
  localparam int PORT_E = 3;
endpackage

// file: logic/io_port_register_set.sv
// How it works
// R1: global pull-up disable bit set turns off every pull-up regardless of direction/latch.
// R2: writing an input-level register toggles matching output latch bits.
// R3: port B output latch is eight bits read/write, reset 0.
// R4: port C output latch bits 6..0 read/write, bit 7 reads 0.
// R5: port D output latch is eight bits read/write, reset 0.
// R6: port E latch drives pins 3..0; bits 7..4 stored, no pin; reset 0.
// R7: direction registers reset to zero; port C direction bit 7 reads 0.
// R8: input-level reads show present pin levels, not a stored value.
// R9: direction one drives pin from latch; zero leaves it an input.
// R10: pins pass a two-flop synchroniser before reaching input-level reads.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module io_port_register_set
  import io_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] port_b_pin_in,
  input wire logic [7:0] port_c_pin_in,
  input wire logic [7:0] port_d_pin_in,
  input wire logic [7:0] port_e_pin_in,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_c_pin_out,
  output logic [7:0] port_d_pin_out,
  output logic [7:0] port_e_pin_out,
  output logic [7:0] port_b_pin_oe_n_out,
  output logic [7:0] port_c_pin_oe_n_out,
  output logic [7:0] port_d_pin_oe_n_out,
  output logic [7:0] port_e_pin_oe_n_out,
  output logic [7:0] port_b_pullup_out,
  output logic [7:0] port_c_pullup_out,
  output logic [7:0] port_d_pullup_out,
  output logic [7:0] port_e_pullup_out
);
  typedef logic [NUM_PORTS-1:0][7:0] port_vec_t;

  typedef struct packed {
    port_vec_t latch_reg;
    port_vec_t dir_reg;
    logic [7:0] mcu_ctrl_reg;
    logic [7:0] rdata_reg;
    port_vec_t pin_drv_reg;
    port_vec_t pin_oe_n_reg;
    port_vec_t pullup_reg;
  } io_state_t;

  io_state_t st_reg;
  io_state_t st_next;
  port_vec_t pins_raw;
  port_vec_t pins_sync;

  // per-port implemented bit mask; port C has no bit 7
  function automatic logic [7:0] impl_mask(input int p);
    impl_mask = (p == PORT_C) ? PORT_C_MASK : 8'hFF;
  endfunction

  // per-port mask of bits that really reach a pin
  function automatic logic [7:0] pin_mask(input int p);
    if (p == PORT_C) begin
      pin_mask = PORT_C_MASK;
    end else if (p == PORT_E) begin
      pin_mask = PORT_E_PIN_MASK;
    end else begin
      pin_mask = 8'hFF;
    end
  endfunction

  // toggle write: flip the latch bits where a one is written, keep the rest
  function automatic logic [7:0] toggled(
    input logic [7:0] latch,
    input logic [7:0] wdata,
    input int p
  );
    toggled = (latch ^ wdata) & impl_mask(p); // [R2]
  endfunction

  // drive value reaches a pin only where the direction bit is set
  function automatic logic [7:0] drive_of(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input int p
  );
    drive_of = latch & dir & pin_mask(p); // [R9]
  endfunction

  // output enable is active low; bits without a pad are never driven
  function automatic logic [7:0] oe_n_of(
    input logic [7:0] dir,
    input int p
  );
    oe_n_of = ~(dir & pin_mask(p)); // [R9]
  endfunction

  // pull-up on an input pin whose latch bit is one, unless globally disabled
  function automatic logic [7:0] pull_of(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic pullup_global_disable,
    input int p
  );
    if (pullup_global_disable) begin
      pull_of = REG_RESET; // [R1]
    end else begin
      pull_of = latch & ~dir & pin_mask(p); // [R9]
    end
  endfunction

  // read mux; unmapped offsets and unimplemented bits read zero
  function automatic logic [7:0] read_value(
    input logic [7:0] a,
    input io_state_t s,
    input port_vec_t pins
  );
    // port b
    if (a == OFF_B_IN) begin
      read_value = pins[PORT_B]; // [R8]
    end else if (a == OFF_B_DIR) begin
      read_value = s.dir_reg[PORT_B]; // [R7]
    end else if (a == OFF_B_OUT) begin
      read_value = s.latch_reg[PORT_B]; // [R3]
    // port c, bit 7 absent
    end else if (a == OFF_C_IN) begin
      read_value = pins[PORT_C] & impl_mask(PORT_C); // [R4] [R8]
    end else if (a == OFF_C_DIR) begin
      read_value = s.dir_reg[PORT_C] & impl_mask(PORT_C); // [R7]
    end else if (a == OFF_C_OUT) begin
      read_value = s.latch_reg[PORT_C] & impl_mask(PORT_C); // [R4]
    // port d
    end else if (a == OFF_D_IN) begin
      read_value = pins[PORT_D]; // [R8]
    end else if (a == OFF_D_DIR) begin
      read_value = s.dir_reg[PORT_D]; // [R7]
    end else if (a == OFF_D_OUT) begin
      read_value = s.latch_reg[PORT_D]; // [R5]
    // port e; upper bits are stored although no pad sits behind them
    end else if (a == OFF_E_IN) begin
      read_value = pins[PORT_E]; // [R8]
    end else if (a == OFF_E_DIR) begin
      read_value = s.dir_reg[PORT_E]; // [R7]
    end else if (a == OFF_E_OUT) begin
      read_value = s.latch_reg[PORT_E]; // [R6]
    // control register
    end else if (a == OFF_MCU_CTRL) begin
      read_value = s.mcu_ctrl_reg; // [R1]
    end else begin
      read_value = REG_RESET;
    end
  endfunction

  assign pins_raw[PORT_B] = port_b_pin_in;
  assign pins_raw[PORT_C] = port_c_pin_in;
  assign pins_raw[PORT_D] = port_d_pin_in;
  assign pins_raw[PORT_E] = port_e_pin_in;

  // one synchroniser per port, pin levels are asynchronous to the core
  generate
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_sync
      pin_sync u_sync (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(pins_raw[g]),
        .sync_out(pins_sync[g])
      ); // [R10]
    end
  endgenerate

  // register writes, read capture and pin drive, all into the next state
  always_comb begin
    logic pullup_global_disable;
    pullup_global_disable = st_reg.mcu_ctrl_reg[PUD_BIT];
    st_next = st_reg;
    // write decode; unmapped offsets are ignored
    if (reg_wr_in) begin
      // port b
      if (reg_addr_in == OFF_B_IN) begin
        st_next.latch_reg[PORT_B] = toggled(st_reg.latch_reg[PORT_B],
                                            reg_wdata_in, PORT_B); // [R2]
      end else if (reg_addr_in == OFF_B_DIR) begin
        st_next.dir_reg[PORT_B] = reg_wdata_in; // [R7]
      end else if (reg_addr_in == OFF_B_OUT) begin
        st_next.latch_reg[PORT_B] = reg_wdata_in; // [R3]
      // port c, bit 7 never stored
      end else if (reg_addr_in == OFF_C_IN) begin
        st_next.latch_reg[PORT_C] = toggled(st_reg.latch_reg[PORT_C],
                                            reg_wdata_in, PORT_C); // [R2]
      end else if (reg_addr_in == OFF_C_DIR) begin
        st_next.dir_reg[PORT_C] = reg_wdata_in & impl_mask(PORT_C); // [R7]
      end else if (reg_addr_in == OFF_C_OUT) begin
        st_next.latch_reg[PORT_C] = reg_wdata_in & impl_mask(PORT_C); // [R4]
      // port d
      end else if (reg_addr_in == OFF_D_IN) begin
        st_next.latch_reg[PORT_D] = toggled(st_reg.latch_reg[PORT_D],
                                            reg_wdata_in, PORT_D); // [R2]
      end else if (reg_addr_in == OFF_D_DIR) begin
        st_next.dir_reg[PORT_D] = reg_wdata_in; // [R7]
      end else if (reg_addr_in == OFF_D_OUT) begin
        st_next.latch_reg[PORT_D] = reg_wdata_in; // [R5]
      // port e; all eight bits stored, only the low four reach pads
      end else if (reg_addr_in == OFF_E_IN) begin
        st_next.latch_reg[PORT_E] = toggled(st_reg.latch_reg[PORT_E],
                                            reg_wdata_in, PORT_E); // [R2]
      end else if (reg_addr_in == OFF_E_DIR) begin
        st_next.dir_reg[PORT_E] = reg_wdata_in; // [R7]
      end else if (reg_addr_in == OFF_E_OUT) begin
        st_next.latch_reg[PORT_E] = reg_wdata_in; // [R6]
      // control register; read-only bits stay zero
      end else if (reg_addr_in == OFF_MCU_CTRL) begin
        st_next.mcu_ctrl_reg = reg_wdata_in & MCU_CTRL_WMASK; // [R1]
      end
    end
    // read data stand one cycle, zero otherwise so a stale value never lingers
    if (reg_rd_in) begin
      st_next.rdata_reg = read_value(reg_addr_in, st_reg, pins_sync); // [R8]
    end else begin
      st_next.rdata_reg = REG_RESET;
    end
    // pin drive follows registers one cycle later
    for (int p = 0; p < NUM_PORTS; p++) begin
      st_next.pin_drv_reg[p] = drive_of(st_reg.latch_reg[p], st_reg.dir_reg[p], p); // [R9]
      st_next.pin_oe_n_reg[p] = oe_n_of(st_reg.dir_reg[p], p); // [R9]
      st_next.pullup_reg[p] = pull_of(st_reg.latch_reg[p], st_reg.dir_reg[p],
                                      pullup_global_disable, p); // [R1]
    end
  end

  // all state in one register; reset clears everything except the output enables, which go to all ones
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_reg.latch_reg <= '0; // [R3] [R5] [R6]
      st_reg.dir_reg <= '0; // [R7]
      st_reg.mcu_ctrl_reg <= REG_RESET;
      st_reg.rdata_reg <= REG_RESET;
      st_reg.pin_drv_reg <= '0;
      st_reg.pin_oe_n_reg <= '1;
      st_reg.pullup_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_out = st_reg.rdata_reg;
  assign port_b_pin_out = st_reg.pin_drv_reg[PORT_B];
  assign port_c_pin_out = st_reg.pin_drv_reg[PORT_C];
  assign port_d_pin_out = st_reg.pin_drv_reg[PORT_D];
  assign port_e_pin_out = st_reg.pin_drv_reg[PORT_E];
  assign port_b_pin_oe_n_out = st_reg.pin_oe_n_reg[PORT_B];
  assign port_c_pin_oe_n_out = st_reg.pin_oe_n_reg[PORT_C];
  assign port_d_pin_oe_n_out = st_reg.pin_oe_n_reg[PORT_D];
  assign port_e_pin_oe_n_out = st_reg.pin_oe_n_reg[PORT_E];
  assign port_b_pullup_out = st_reg.pullup_reg[PORT_B];
  assign port_c_pullup_out = st_reg.pullup_reg[PORT_C];
  assign port_d_pullup_out = st_reg.pullup_reg[PORT_D];
  assign port_e_pullup_out = st_reg.pullup_reg[PORT_E];
endmodule

// file: logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import io_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);
  typedef struct packed {
    logic [7:0] stage1_reg;
    logic [7:0] stage2_reg;
  } sync_state_t;
  sync_state_t st_reg;
  sync_state_t st_next;

  // first stage feeds only the second one
  always_comb begin
    st_next = st_reg;
    st_next.stage1_reg = async_in;
    st_next.stage2_reg = st_reg.stage1_reg;
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '{REG_RESET, REG_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stage2_reg;
endmodule
